/* File: secure_packet_encoder_defs.svh */
`ifndef SECURE_PACKET_ENCODER_DEFS_SVH
`define SECURE_PACKET_ENCODER_DEFS_SVH

// ----------------------------------------
// Timing
// ----------------------------------------
`define SPE_CLK_HZ        250000000
`define SPE_BAUD_LO_BPS   4800
`define SPE_BAUD_HI_BPS   28800
`define SPE_BITCYC_LO     (`SPE_CLK_HZ / `SPE_BAUD_LO_BPS)
`define SPE_BITCYC_HI     (`SPE_CLK_HZ / `SPE_BAUD_HI_BPS)
`define SPE_RATE_SETTLE   2'h3
`define SPE_CIPH_ROUNDS   6'h20
`define SPE_FRAME_BITS    129
`define SPE_FRAME_LAST    8'h80
`define SPE_HALF_BITS     8'h40

// ----------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------
`define SPE_A_KEY0        8'h00
`define SPE_A_KEY1        8'h04
`define SPE_A_KEY2        8'h08
`define SPE_A_CNT0        8'h0c
`define SPE_A_CNT1        8'h10
`define SPE_A_IDENT       8'h14
`define SPE_A_CTRL        8'h18
`define SPE_A_STATUS      8'h1c
`define SPE_A_LIVE0       8'h20
`define SPE_A_LIVE1       8'h24

// ----------------------------------------
// Fields
// ----------------------------------------
`define SPE_CTRL_COMMIT   0
`define SPE_CTRL_FORGET   1
`define SPE_ST_ASSOC      0
`define SPE_ST_ACTIVE     1
`define SPE_ST_RATE       2
`define SPE_ST_SERBUSY    3
`define SPE_ST_RATEDONE   4
`define SPE_ST_LINES_LSB  8

// ----------------------------------------
// Reset values
// ----------------------------------------
`define SPE_RST_WORD      32'h0
`define SPE_RST_KEY       80'h0
`define SPE_RST_CNT       40'h0
`define SPE_RST_IDENT     16'h0

`endif

/* File: secure_packet_encoder_pkg.sv */
package secure_packet_encoder_pkg;

  // Packet builder states
  typedef enum logic [4:0] {
    ST_IDLE = 5'h01,
    ST_TAG  = 5'h02,
    ST_BLK1 = 5'h04,
    ST_BLK2 = 5'h08,
    ST_SEND = 5'h10
  } encState_t;

  // Cipher core states
  typedef enum logic [1:0] {
    CI_IDLE = 2'h1,
    CI_RUN  = 2'h2
  } cipState_t;

  // Serializer states
  typedef enum logic [1:0] {
    SER_IDLE  = 2'h1,
    SER_SHIFT = 2'h2
  } serState_t;

endpackage

/* File: block_cipher_core.sv */
`timescale 1ns/10ps
`include "secure_packet_encoder_defs.svh"

module block_cipher_core
  import secure_packet_encoder_pkg::*;
(
  input  wire logic        mclk,      // System clock
  input  wire logic        resetn,    // Synchronous reset, active low
  input  wire logic        start,     // Begin one block, only when idle
  input  wire logic [79:0] key,       // Cipher key
  input  wire logic [63:0] blockIn,   // Plain block
  output logic             done,      // One-cycle pulse, result valid
  output logic      [63:0] blockOut   // Cipher block, held until next start
);

  // ----------------------------------------
  // Round function
  // ----------------------------------------
  function automatic logic [31:0] roundF(input logic [31:0] r, input logic [31:0] k);
    logic [31:0] t;
    t = {r[28:0], r[31:29]} ^ ({r[26:0], r[31:27]} & {r[0], r[31:1]});
    roundF = t + k;
  endfunction

  cipState_t   state_r,  state_nxt;
  logic [31:0] left_r,   left_nxt;
  logic [31:0] right_r,  right_nxt;
  logic [79:0] kSched_r, kSched_nxt;
  logic [5:0]  round_r,  round_nxt;
  logic        done_r,   done_nxt;

  // 32-round Feistel, one round per clock, key rotated each round
  always_comb begin
    state_nxt  = state_r;
    left_nxt   = left_r;
    right_nxt  = right_r;
    kSched_nxt = kSched_r;
    round_nxt  = round_r;
    done_nxt   = 1'b0;
    unique case (state_r)
      CI_IDLE: begin
        if (start) begin
          left_nxt   = blockIn[63:32];
          right_nxt  = blockIn[31:0];
          kSched_nxt = key;
          round_nxt  = 6'h0;
          state_nxt  = CI_RUN;
        end
      end
      CI_RUN: begin
        left_nxt   = right_r;
        right_nxt  = left_r ^ roundF(right_r, kSched_r[79:48] ^ {26'h0, round_r});
        kSched_nxt = {kSched_r[66:0], kSched_r[79:67]};
        round_nxt  = round_r + 6'h1;
        if (round_r == `SPE_CIPH_ROUNDS - 6'h1) begin
          done_nxt  = 1'b1;
          state_nxt = CI_IDLE;
        end
      end
      default: state_nxt = CI_IDLE;
    endcase
  end

  // State registers
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      state_r  <= CI_IDLE;
      left_r   <= 32'h0;
      right_r  <= 32'h0;
      kSched_r <= `SPE_RST_KEY;
      round_r  <= 6'h0;
      done_r   <= 1'b0;
    end else begin
      state_r  <= state_nxt;
      left_r   <= left_nxt;
      right_r  <= right_nxt;
      kSched_r <= kSched_nxt;
      round_r  <= round_nxt;
      done_r   <= done_nxt;
    end
  end

  assign done     = done_r;
  assign blockOut = {left_r, right_r};

endmodule

/* File: packet_serializer.sv */
`timescale 1ns/10ps
`include "secure_packet_encoder_defs.svh"

module packet_serializer
  import secure_packet_encoder_pkg::*;
#(
  parameter logic [15:0] BIT_CYC_LO = 16'(`SPE_BITCYC_LO),
  parameter logic [15:0] BIT_CYC_HI = 16'(`SPE_BITCYC_HI)
)
(
  input  wire logic         mclk,       // System clock
  input  wire logic         resetn,     // Synchronous reset, active low
  input  wire logic         load,       // Take frame, only when not busy
  input  wire logic [128:0] frame,      // Frame, sent MSB first
  input  wire logic         rateHigh,   // High selects the fast bit rate
  output logic              busy,       // Frame in flight
  output logic              serialOut   // Serial bit stream, idles low
);

  serState_t    state_r, state_nxt;
  logic [128:0] shift_r, shift_nxt;
  logic [7:0]   bitCnt_r, bitCnt_nxt;
  logic [15:0]  baud_r,  baud_nxt;
  logic         out_r,   out_nxt;
  logic [15:0]  period;

  // Bit period minus one for the chosen rate
  assign period = (rateHigh ? BIT_CYC_HI : BIT_CYC_LO) - 16'h1;

  // Shift one bit per period
  always_comb begin
    state_nxt  = state_r;
    shift_nxt  = shift_r;
    bitCnt_nxt = bitCnt_r;
    baud_nxt   = baud_r;
    out_nxt    = out_r;
    unique case (state_r)
      SER_IDLE: begin
        out_nxt = 1'b0;
        if (load) begin
          shift_nxt  = frame;
          out_nxt    = frame[128];
          bitCnt_nxt = `SPE_FRAME_LAST;
          baud_nxt   = period;
          state_nxt  = SER_SHIFT;
        end
      end
      SER_SHIFT: begin
        if (baud_r != 16'h0) begin
          baud_nxt = baud_r - 16'h1;
        end else if (bitCnt_r == 8'h0) begin
          out_nxt   = 1'b0;
          state_nxt = SER_IDLE;
        end else begin
          shift_nxt  = {shift_r[127:0], 1'b0};
          out_nxt    = shift_r[127];
          bitCnt_nxt = bitCnt_r - 8'h1;
          baud_nxt   = period;
        end
      end
      default: state_nxt = SER_IDLE;
    endcase
  end

  // State registers
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      state_r  <= SER_IDLE;
      shift_r  <= 129'h0;
      bitCnt_r <= 8'h0;
      baud_r   <= 16'h0;
      out_r    <= 1'b0;
    end else begin
      state_r  <= state_nxt;
      shift_r  <= shift_nxt;
      bitCnt_r <= bitCnt_nxt;
      baud_r   <= baud_nxt;
      out_r    <= out_nxt;
    end
  end

  assign busy      = (state_r == SER_SHIFT);
  assign serialOut = out_r;

endmodule

/* File: secure_packet_encoder.sv */
// Function
// - Message: lines, counter, integrity, 128 bits
// - Authenticated encryption of every message
// - Packets back to back while send high
// - Counter decrements on every packet
// - Key, counter, identifier accepted and kept
// - Send high captures lines per packet, transmits serially
// - Power control follows send input
// - Rate select sampled once after reset
// - Invert packet when ones exceed half
`timescale 1ns/10ps
`include "secure_packet_encoder_defs.svh"

module secure_packet_encoder
  import secure_packet_encoder_pkg::*;
#(
  parameter logic [15:0] BIT_CYC_LO = 16'(`SPE_BITCYC_LO),
  parameter logic [15:0] BIT_CYC_HI = 16'(`SPE_BITCYC_HI)
)
(
  input  wire logic        mclk,                    // System clock, 250 MHz
  input  wire logic        resetn,                  // Synchronous reset, active low
  input  wire logic        psel,                    // APB select
  input  wire logic        penable,                 // APB enable
  input  wire logic        pwrite,                  // APB write
  input  wire logic [7:0]  paddr,                   // APB byte address
  input  wire logic [31:0] pwdata,                  // APB write data
  output logic      [31:0] prdata,                  // APB read data
  output logic             pready,                  // APB ready
  output logic             pslverr,                 // APB error, unmapped address
  input  wire logic        sendIn,                  // Send request pin
  input  wire logic [7:0]  buttonInputLines,        // Button input pins
  input  wire logic        rateSelect,              // Bit rate strap pin
  output logic             dataOut,                 // Serial packet output
  output logic             transmitterPowerControl  // Transmitter power enable
);

  // ----------------------------------------
  // Pin synchronisers and rate strap
  // ----------------------------------------
  logic       sendMeta_r, sendSync_r;
  logic [7:0] btnMeta_r,  btnSync_r;
  logic       rateMeta_r, rateSync_r;
  logic       txPwr_r,    txPwr_nxt;
  logic       rateHigh_r, rateHigh_nxt;
  logic       rateDone_r, rateDone_nxt;
  logic [1:0] rateWait_r, rateWait_nxt;

  // Strap taken once after the synchroniser has settled
  always_comb begin
    txPwr_nxt    = sendSync_r;
    rateHigh_nxt = rateHigh_r;
    rateDone_nxt = rateDone_r;
    rateWait_nxt = rateWait_r;
    if (!rateDone_r) begin
      if (rateWait_r == `SPE_RATE_SETTLE) begin
        rateHigh_nxt = rateSync_r;
        rateDone_nxt = 1'b1;
      end else begin
        rateWait_nxt = rateWait_r + 2'h1;
      end
    end
  end

  // Two-stage synchronisers and strap registers
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      sendMeta_r <= 1'b0;
      sendSync_r <= 1'b0;
      btnMeta_r  <= 8'h0;
      btnSync_r  <= 8'h0;
      rateMeta_r <= 1'b0;
      rateSync_r <= 1'b0;
      txPwr_r    <= 1'b0;
      rateHigh_r <= 1'b0;
      rateDone_r <= 1'b0;
      rateWait_r <= 2'h0;
    end else begin
      sendMeta_r <= sendIn;
      sendSync_r <= sendMeta_r;
      btnMeta_r  <= buttonInputLines;
      btnSync_r  <= btnMeta_r;
      rateMeta_r <= rateSelect;
      rateSync_r <= rateMeta_r;
      txPwr_r    <= txPwr_nxt;
      rateHigh_r <= rateHigh_nxt;
      rateDone_r <= rateDone_nxt;
      rateWait_r <= rateWait_nxt;
    end
  end

  // ----------------------------------------
  // APB slave and staging registers
  // ----------------------------------------
  logic [31:0] prdata_r,  prdata_nxt;
  logic        pready_r,  pready_nxt;
  logic        pslverr_r, pslverr_nxt;
  logic [79:0] stKey_r,   stKey_nxt;
  logic [39:0] stCnt_r,   stCnt_nxt;
  logic [15:0] stId_r,    stId_nxt;
  logic        commit_r,  commit_nxt;
  logic        forget_r,  forget_nxt;
  logic        apbWr;
  logic        hit;
  logic [31:0] rdMux;
  logic [31:0] statusWord;

  // Working association and builder state, declared here for the read mux
  encState_t   state_r,   state_nxt;
  logic [79:0] key_r,     key_nxt;
  logic [39:0] cnt_r,     cnt_nxt;
  logic [15:0] id_r,      id_nxt;
  logic        assoc_r,   assoc_nxt;
  logic [7:0]  lines_r,   lines_nxt;
  logic        serBusy;

  assign statusWord = {16'h0, lines_r, 3'h0, rateDone_r, serBusy, rateHigh_r,
                       (state_r != ST_IDLE), assoc_r};

  // Zero-wait answer, write lands at the access edge
  always_comb begin
    apbWr       = psel & penable & pready_r & pwrite & ~pslverr_r;
    hit         = 1'b1;
    rdMux       = `SPE_RST_WORD;
    unique case (paddr)
      `SPE_A_KEY0:   rdMux = stKey_r[31:0];
      `SPE_A_KEY1:   rdMux = stKey_r[63:32];
      `SPE_A_KEY2:   rdMux = {16'h0, stKey_r[79:64]};
      `SPE_A_CNT0:   rdMux = stCnt_r[31:0];
      `SPE_A_CNT1:   rdMux = {24'h0, stCnt_r[39:32]};
      `SPE_A_IDENT:  rdMux = {16'h0, stId_r};
      `SPE_A_CTRL:   rdMux = `SPE_RST_WORD;
      `SPE_A_STATUS: rdMux = statusWord;
      `SPE_A_LIVE0:  rdMux = cnt_r[31:0];
      `SPE_A_LIVE1:  rdMux = {24'h0, cnt_r[39:32]};
      default:       hit   = 1'b0;
    endcase
    pready_nxt  = psel & ~penable;
    pslverr_nxt = psel & ~penable & ~hit;
    prdata_nxt  = (psel & ~penable) ? rdMux : prdata_r;
    stKey_nxt   = stKey_r;
    stCnt_nxt   = stCnt_r;
    stId_nxt    = stId_r;
    commit_nxt  = 1'b0;
    forget_nxt  = 1'b0;
    if (apbWr) begin
      unique case (paddr)
        `SPE_A_KEY0:  stKey_nxt[31:0]  = pwdata;
        `SPE_A_KEY1:  stKey_nxt[63:32] = pwdata;
        `SPE_A_KEY2:  stKey_nxt[79:64] = pwdata[15:0];
        `SPE_A_CNT0:  stCnt_nxt[31:0]  = pwdata;
        `SPE_A_CNT1:  stCnt_nxt[39:32] = pwdata[7:0];
        `SPE_A_IDENT: stId_nxt         = pwdata[15:0];
        `SPE_A_CTRL: begin
          commit_nxt = pwdata[`SPE_CTRL_COMMIT];
          forget_nxt = pwdata[`SPE_CTRL_FORGET];
        end
        default: ;
      endcase
    end
  end

  // APB registers
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      prdata_r  <= `SPE_RST_WORD;
      pready_r  <= 1'b0;
      pslverr_r <= 1'b0;
      stKey_r   <= `SPE_RST_KEY;
      stCnt_r   <= `SPE_RST_CNT;
      stId_r    <= `SPE_RST_IDENT;
      commit_r  <= 1'b0;
      forget_r  <= 1'b0;
    end else begin
      prdata_r  <= prdata_nxt;
      pready_r  <= pready_nxt;
      pslverr_r <= pslverr_nxt;
      stKey_r   <= stKey_nxt;
      stCnt_r   <= stCnt_nxt;
      stId_r    <= stId_nxt;
      commit_r  <= commit_nxt;
      forget_r  <= forget_nxt;
    end
  end

  // ----------------------------------------
  // Packet builder
  // ----------------------------------------
  logic [39:0]  pktCnt_r,  pktCnt_nxt;
  logic [63:0]  tag_r,     tag_nxt;
  logic [63:0]  c1_r,      c1_nxt;
  logic [127:0] pkt_r,     pkt_nxt;
  logic [63:0]  cipBlk_r,  cipBlk_nxt;
  logic         cipStart_r, cipStart_nxt;
  logic         serLoad_r, serLoad_nxt;
  logic [128:0] frame_r,   frame_nxt;
  logic         cipDone;
  logic [63:0]  cipOut;
  logic         startPkt;
  logic         invert;

  // Number of ones in a packet
  function automatic logic [7:0] onesCount(input logic [127:0] v);
    logic [7:0] n;
    n = 8'h0;
    for (int i = 0; i < 128; i++) begin
      n = n + {7'h0, v[i]};
    end
    onesCount = n;
  endfunction

  assign invert = (onesCount(pkt_r) > `SPE_HALF_BITS);

  // Tag, then two chained blocks, then hand to the serializer
  always_comb begin
    state_nxt    = state_r;
    key_nxt      = key_r;
    cnt_nxt      = cnt_r;
    id_nxt       = id_r;
    assoc_nxt    = assoc_r;
    lines_nxt    = lines_r;
    pktCnt_nxt   = pktCnt_r;
    tag_nxt      = tag_r;
    c1_nxt       = c1_r;
    pkt_nxt      = pkt_r;
    cipBlk_nxt   = cipBlk_r;
    cipStart_nxt = 1'b0;
    serLoad_nxt  = 1'b0;
    frame_nxt    = frame_r;
    startPkt     = 1'b0;
    unique case (state_r)
      ST_IDLE: begin
        startPkt = sendSync_r & assoc_r & rateDone_r;
      end
      ST_TAG: begin
        if (cipDone) begin
          tag_nxt      = cipOut;
          cipBlk_nxt   = {lines_r, pktCnt_r, id_r};
          cipStart_nxt = 1'b1;
          state_nxt    = ST_BLK1;
        end
      end
      ST_BLK1: begin
        if (cipDone) begin
          c1_nxt       = cipOut;
          cipBlk_nxt   = tag_r ^ cipOut;
          cipStart_nxt = 1'b1;
          state_nxt    = ST_BLK2;
        end
      end
      ST_BLK2: begin
        if (cipDone) begin
          pkt_nxt   = {c1_r, cipOut};
          state_nxt = ST_SEND;
        end
      end
      ST_SEND: begin
        if (!serBusy && !serLoad_r) begin
          serLoad_nxt = 1'b1;
          frame_nxt   = {invert, invert ? ~pkt_r : pkt_r};
          state_nxt   = ST_IDLE;
          startPkt    = sendSync_r & assoc_r;
        end
      end
      default: state_nxt = ST_IDLE;
    endcase
    // Exhausted counter drops the key instead of sending
    if (startPkt) begin
      if (cnt_r == 40'h0) begin
        assoc_nxt = 1'b0;
        key_nxt   = `SPE_RST_KEY;
        state_nxt = ST_IDLE;
      end else begin
        lines_nxt    = btnSync_r;
        pktCnt_nxt   = cnt_r;
        cnt_nxt      = cnt_r - 40'h1;
        cipBlk_nxt   = ~{btnSync_r, cnt_r, id_r};
        cipStart_nxt = 1'b1;
        state_nxt    = ST_TAG;
      end
    end
    if (forget_r) begin
      assoc_nxt = 1'b0;
    end
    // Association load wins over any clear in the same cycle
    if (commit_r) begin
      key_nxt   = stKey_r;
      cnt_nxt   = stCnt_r;
      id_nxt    = stId_r;
      assoc_nxt = 1'b1;
    end
  end

  // Builder registers
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      state_r    <= ST_IDLE;
      key_r      <= `SPE_RST_KEY;
      cnt_r      <= `SPE_RST_CNT;
      id_r       <= `SPE_RST_IDENT;
      assoc_r    <= 1'b0;
      lines_r    <= 8'h0;
      pktCnt_r   <= `SPE_RST_CNT;
      tag_r      <= 64'h0;
      c1_r       <= 64'h0;
      pkt_r      <= 128'h0;
      cipBlk_r   <= 64'h0;
      cipStart_r <= 1'b0;
      serLoad_r  <= 1'b0;
      frame_r    <= 129'h0;
    end else begin
      state_r    <= state_nxt;
      key_r      <= key_nxt;
      cnt_r      <= cnt_nxt;
      id_r       <= id_nxt;
      assoc_r    <= assoc_nxt;
      lines_r    <= lines_nxt;
      pktCnt_r   <= pktCnt_nxt;
      tag_r      <= tag_nxt;
      c1_r       <= c1_nxt;
      pkt_r      <= pkt_nxt;
      cipBlk_r   <= cipBlk_nxt;
      cipStart_r <= cipStart_nxt;
      serLoad_r  <= serLoad_nxt;
      frame_r    <= frame_nxt;
    end
  end

  // ----------------------------------------
  // Submodules
  // ----------------------------------------
  // Block cipher, three runs per packet
  block_cipher_core u_cipher (
    .mclk     (mclk),
    .resetn   (resetn),
    .start    (cipStart_r),
    .key      (key_r),
    .blockIn  (cipBlk_r),
    .done     (cipDone),
    .blockOut (cipOut)
  );

  // Frame serializer at the strapped rate
  packet_serializer #(
    .BIT_CYC_LO (BIT_CYC_LO),
    .BIT_CYC_HI (BIT_CYC_HI)
  ) u_serial (
    .mclk      (mclk),
    .resetn    (resetn),
    .load      (serLoad_r),
    .frame     (frame_r),
    .rateHigh  (rateHigh_r),
    .busy      (serBusy),
    .serialOut (dataOut)
  );

  // Outputs
  assign prdata                  = prdata_r;
  assign pready                  = pready_r;
  assign pslverr                 = pslverr_r;
  assign transmitterPowerControl = txPwr_r;

endmodule

/* File: secure_packet_encoder_asserts.sv */
`timescale 1ns/10ps

module secure_packet_encoder_asserts #(
  parameter logic [15:0] BIT_CYC_LO = 16'h8,
  parameter logic [15:0] BIT_CYC_HI = 16'h4
)
(
  input wire logic        mclk,                    // Clock
  input wire logic        resetn,                  // Reset, active low
  input wire logic        psel,                    // APB select
  input wire logic        penable,                 // APB enable
  input wire logic        pwrite,                  // APB write
  input wire logic [7:0]  paddr,                   // APB address
  input wire logic [31:0] prdata,                  // APB read data
  input wire logic        pready,                  // APB ready
  input wire logic        pslverr,                 // APB error
  input wire logic        sendIn,                  // Send pin
  input wire logic        dataOut,                 // Serial output
  input wire logic        transmitterPowerControl  // Power control
);
  localparam int QUIET_MAX = 2 * 129 * int'(BIT_CYC_LO) + 300;
  logic [15:0] quiet_r;
  logic [15:0] quiet_nxt;

  // Cycles since send was last high, saturating
  always_comb begin
    quiet_nxt = quiet_r;
    if (sendIn)
      quiet_nxt = 16'h0;
    else if (quiet_r != 16'hffff)
      quiet_nxt = quiet_r + 16'h1;
  end
  always_ff @(posedge mclk) begin
    if (!resetn)
      quiet_r <= 16'h0;
    else
      quiet_r <= quiet_nxt;
  end

  default clocking @(posedge mclk); endclocking
  default disable iff (!resetn);

  property p_pwrOn; sendIn [*4] |-> transmitterPowerControl; endproperty
  a_pwrOn: assert property (p_pwrOn) else $error("power control low");
  property p_pwrOff; !sendIn [*4] |-> !transmitterPowerControl; endproperty
  a_pwrOff: assert property (p_pwrOff) else $error("power control high");
  property p_pwrLag; $rose(sendIn) ##1 sendIn [*2] |=> $rose(transmitterPowerControl); endproperty
  a_pwrLag: assert property (p_pwrLag) else $error("power control lag");
  property p_ready; psel && !penable |=> pready; endproperty
  a_ready: assert property (p_ready) else $error("no ready in access");
  property p_readyOnce; pready |=> !pready; endproperty
  a_readyOnce: assert property (p_readyOnce) else $error("ready too long");
  property p_unmapped; psel && !penable && paddr > 8'h24 |=> pslverr && prdata == 32'h0; endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped not refused");
  property p_ctrlZero; psel && !penable && !pwrite && paddr == 8'h18 |=> prdata == 32'h0; endproperty
  a_ctrlZero: assert property (p_ctrlZero) else $error("control read not zero");
  property p_bitHold; $rose(dataOut) |=> dataOut [*3]; endproperty
  a_bitHold: assert property (p_bitHold) else $error("serial bit too short");
  property p_quiet; int'(quiet_r) >= QUIET_MAX |-> !dataOut; endproperty
  a_quiet: assert property (p_quiet) else $error("data after send low");
endmodule

bind secure_packet_encoder secure_packet_encoder_asserts #(
  .BIT_CYC_LO(BIT_CYC_LO),
  .BIT_CYC_HI(BIT_CYC_HI)
) secure_packet_encoder_asserts_i (
  .mclk, .resetn, .psel, .penable, .pwrite, .paddr, .prdata, .pready, .pslverr,
  .sendIn, .dataOut, .transmitterPowerControl
);

/* File: air_monitor.sv */
`timescale 1ns/10ps

module air_monitor (
  input  wire logic        mclk,       // Clock
  input  wire logic        resetn,     // Reset, active low
  input  wire logic        dataOut,    // Keyed carrier data
  output logic      [19:0] highCycles  // Cycles with carrier on
);
  logic [19:0] high_r;
  logic [19:0] high_nxt;

  // Carrier on-time seen by the receiver; line gating stays there
  always_comb begin
    high_nxt = high_r + 20'(dataOut);
  end
  always_ff @(posedge mclk) begin
    if (!resetn)
      high_r <= 20'h0;
    else
      high_r <= high_nxt;
  end
  assign highCycles = high_r;
endmodule

/* File: tb_secure_packet_encoder.sv */
`timescale 1ns/10ps
`include "secure_packet_encoder_defs.svh"

module tb_secure_packet_encoder;
  localparam logic [15:0] BLO = 16'h8;
  localparam logic [15:0] BHI = 16'h4;
  logic        mclk, resetn, psel, penable, pwrite, sendIn, rateSelect;
  logic [7:0]  paddr, buttonInputLines;
  logic [31:0] pwdata, prdata, rdData;
  logic        pready, pslverr, dataOut, transmitterPowerControl;
  logic [19:0] highCycles;
  integer      seed, num_errors, checks;

  secure_packet_encoder #(.BIT_CYC_LO(BLO), .BIT_CYC_HI(BHI)) secure_packet_encoder_i (
    .mclk, .resetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .sendIn, .buttonInputLines, .rateSelect, .dataOut, .transmitterPowerControl
  );
  air_monitor air_monitor_i (.mclk, .resetn, .dataOut, .highCycles);

  // Clock, 4 ns period
  always #2 mclk = ~mclk;

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks = checks + 1;
    if (seen !== exp) begin
      num_errors = num_errors + 1;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    do begin
      @(posedge mclk);
      n++;
    end while (pready !== 1'b1 && n < 64);
    rdData = prdata;
    if (n >= 64) check("pready", 32'h0, 32'h1);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge mclk);
  endtask

  task automatic rdChk(input string what, input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    check(what, rdData, exp);
  endtask

  function automatic logic [31:0] regMask(input logic [7:0] a);
    case (a)
      `SPE_A_KEY2, `SPE_A_IDENT: return 32'h0000ffff;
      `SPE_A_CNT1: return 32'h000000ff;
      default: return 32'hffffffff;
    endcase
  endfunction

  function automatic logic [31:0] statusExp(input logic s, input logic r, input logic [7:0] l);
    return {16'h0, l, 3'h0, 1'b1, 1'b0, r, 1'b0, s};
  endfunction

  // Load staging set from the partner and commit it
  task automatic associate(input logic [39:0] cnt);
    logic [79:0] key;
    key = 80'h0;
    for (int i = 0; i < 20; i++)
      key = {key[75:0], 4'($random(seed))};
    apb(1'b1, `SPE_A_KEY0, key[31:0]);
    apb(1'b1, `SPE_A_KEY1, key[63:32]);
    apb(1'b1, `SPE_A_KEY2, {16'h0, key[79:64]});
    apb(1'b1, `SPE_A_CNT0, cnt[31:0]);
    apb(1'b1, `SPE_A_CNT1, {24'h0, cnt[39:32]});
    apb(1'b1, `SPE_A_IDENT, {16'h0, 16'($random(seed))});
    apb(1'b1, `SPE_A_CTRL, 32'h1);
    rdChk("live0", `SPE_A_LIVE0, cnt[31:0]);
  endtask

  task automatic runRate(input logic rate);
    logic [15:0] bc;
    logic [39:0] cnt;
    logic [7:0]  lines;
    logic [19:0] hc;
    bc = rate ? BHI : BLO;
    resetn <= 1'b0;
    rateSelect <= rate;
    sendIn <= 1'b0;
    repeat (2) @(posedge mclk);
    resetn <= 1'b1;
    repeat (6) @(posedge mclk);
    rateSelect <= ~rate;
    rdChk("status", `SPE_A_STATUS, statusExp(1'b0, rate, 8'h0));
    rdChk("unmapped", 8'h28, 32'h0);
    // Staging registers: reset value, then random readback
    for (int i = 0; i < 6; i++) begin
      cnt[31:0] = $random(seed);
      rdChk("stage reset", 8'(4 * i), 32'h0);
      apb(1'b1, 8'(4 * i), cnt[31:0]);
      rdChk("stage", 8'(4 * i), cnt[31:0] & regMask(8'(4 * i)));
    end
    $display("rate %0d registers done", rate);
    // Send while unassociated: power follows, nothing on air
    hc = highCycles;
    buttonInputLines <= 8'($random(seed));
    sendIn <= 1'b1;
    repeat (400) @(posedge mclk);
    check("power on", 32'(transmitterPowerControl), 32'h1);
    sendIn <= 1'b0;
    repeat (8) @(posedge mclk);
    check("power off", 32'(transmitterPowerControl), 32'h0);
    check("no frame", 32'(highCycles - hc), 32'h0);
    $display("rate %0d unassociated done", rate);
    // Counter of three: three packets, then association dropped
    associate(40'h3);
    lines = 8'($random(seed));
    buttonInputLines <= lines;
    hc = highCycles;
    sendIn <= 1'b1;
    repeat (4 * (129 * bc + 120)) @(posedge mclk);
    sendIn <= 1'b0;
    repeat (8) @(posedge mclk);
    rdChk("live0", `SPE_A_LIVE0, 32'h0);
    rdChk("status", `SPE_A_STATUS, statusExp(1'b0, rate, lines));
    check("duty", 32'(highCycles != hc && highCycles - hc <= 20'(192 * bc)), 32'h1);
    $display("rate %0d exhaustion done", rate);
    // Short send: one packet, then the air goes quiet
    cnt = {8'h80, 32'($random(seed))};
    associate(cnt);
    sendIn <= 1'b1;
    repeat (40) @(posedge mclk);
    sendIn <= 1'b0;
    repeat (129 * bc + 300) @(posedge mclk);
    cnt = cnt - 40'h1;
    rdChk("live0", `SPE_A_LIVE0, cnt[31:0]);
    rdChk("live1", `SPE_A_LIVE1, {24'h0, cnt[39:32]});
    hc = highCycles;
    repeat (1500) @(posedge mclk);
    check("quiet", 32'(highCycles - hc), 32'h0);
    // Forget drops the association, commit wins over forget
    apb(1'b1, `SPE_A_CTRL, 32'h2);
    rdChk("forget", `SPE_A_STATUS, statusExp(1'b0, rate, lines));
    apb(1'b1, `SPE_A_CTRL, 32'h3);
    rdChk("commit wins", `SPE_A_STATUS, statusExp(1'b1, rate, lines));
    rdChk("ctrl", `SPE_A_CTRL, 32'h0);
    $display("rate %0d single packet done", rate);
  endtask

  task automatic complete_run();
    $display("checks %0d errors %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  // Main sequence, both strap settings
  initial begin
    seed = 32'h9242fe47;
    num_errors = 0;
    checks = 0;
    mclk = 1'b0;
    resetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h0;
    pwdata = 32'h0;
    sendIn = 1'b0;
    buttonInputLines = 8'h0;
    rateSelect = 1'b0;
    runRate(1'b0);
    runRate(1'b1);
    complete_run();
  end

  // Watchdog against a hung handshake
  initial begin
    repeat (60000) @(posedge mclk);
    check("watchdog", 32'h1, 32'h0);
    complete_run();
  end
endmodule
